// ==== atc2_pkg.sv ====
// Package with register map, field layout and encodings of the timer block.
package atc2_pkg;

  localparam int ADDR_W = 12;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_CONTROL_A = 10'h0B0;
  localparam logic [9:0] IDX_CONTROL_B = 10'h0B1;
  localparam logic [9:0] IDX_COUNTER = 10'h0B2;
  localparam logic [9:0] IDX_COMPARE_A = 10'h0B3;
  localparam logic [9:0] IDX_COMPARE_B = 10'h0B4;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0B5;
  localparam logic [9:0] IDX_ASYNC_STATUS = 10'h0B6;
  localparam logic [9:0] IDX_IRQ_FLAGS = 10'h037;

  // Field positions.
  localparam int CA_COM_A_LSB = 6;
  localparam int CA_COM_B_LSB = 4;
  localparam int CB_FORCE_A = 7;
  localparam int CB_FORCE_B = 6;
  localparam int CB_WGM_HIGH = 3;
  localparam int AS_EXTERNAL_CLOCK_ENABLE = 6;
  localparam int AS_ASYNC = 5;
  localparam int UB_COUNTER = 4;
  localparam int UB_COMPARE_A = 3;
  localparam int UB_COMPARE_B = 2;
  localparam int UB_CONTROL_A = 1;
  localparam int UB_CONTROL_B = 0;
  localparam int IRQ_COMPARE_B = 2;
  localparam int IRQ_COMPARE_A = 1;
  localparam int IRQ_OVERFLOW = 0;

  // Implemented bits and reset values.
  localparam logic [7:0] CA_MASK = 8'hF3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_CB = 4'h0;
  localparam logic [4:0] RESET_BUSY = 5'h00;
  localparam logic [2:0] RESET_IRQ = 3'h0;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // Prescaler masks for clock select codes 2 to 7.
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV32_MASK = 10'h01F;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV128_MASK = 10'h07F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WAVE_NORMAL, WAVE_CTC, WAVE_FAST, WAVE_PHASE} atc2_wave_t;

endpackage

// ==== atc2_prescaler.sv ====
// Prescaler that turns timer source ticks into counter ticks.
`timescale 1ns/1ns
`default_nettype none
module atc2_prescaler
  import atc2_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic src_tick,
  input wire logic [2:0] clock_select_field,
  output logic tick
);

  logic [9:0] div_r;
  logic [9:0] div_nxt;
  logic [9:0] mask;

  always_comb begin
    div_nxt = src_tick ? div_r + 10'h001 : div_r;
    mask = DIV1024_MASK;
    unique case (clock_select_field)
      3'h0, 3'h1: mask = 10'h000;
      3'h2: mask = DIV8_MASK;
      3'h3: mask = DIV32_MASK;
      3'h4: mask = DIV64_MASK;
      3'h5: mask = DIV128_MASK;
      3'h6: mask = DIV256_MASK;
      3'h7: mask = DIV1024_MASK;
    endcase
    // Code zero stops the counter; code one passes the source clock undivided and the rest divide it.
    tick = src_tick && (clock_select_field != 3'h0) && ((div_r & mask) == mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== atc2_compare.sv ====
// Waveform output of one compare channel.
`timescale 1ns/1ns
`default_nettype none
module atc2_compare
  import atc2_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic match,
  input wire logic force_strobe,
  input wire logic at_bottom,
  input wire logic counting_down,
  input wire logic toggle_ok,
  input wire atc2_wave_t wave,
  input wire logic [1:0] output_mode,
  output logic wave_out
);

  logic out_r;
  logic out_nxt;

  always_comb begin
    out_nxt = out_r;
    if (force_strobe || (match && (wave == WAVE_NORMAL || wave == WAVE_CTC))) begin
      // A forced match acts through the output mode bits of this moment.
      unique case (output_mode)
        2'h0: out_nxt = out_r;
        2'h1: out_nxt = !out_r;
        2'h2: out_nxt = 1'b0;
        2'h3: out_nxt = 1'b1;
      endcase
    end else if (match) begin
      // A match drives the waveform output.
      unique case (output_mode)
        2'h0: out_nxt = out_r;
        2'h1: out_nxt = toggle_ok ? !out_r : out_r;
        2'h2: out_nxt = (wave == WAVE_PHASE) && counting_down;
        2'h3: out_nxt = !((wave == WAVE_PHASE) && counting_down);
      endcase
    end else if (at_bottom && wave == WAVE_FAST && output_mode[1]) begin
      out_nxt = !output_mode[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign wave_out = out_r;

endmodule
`default_nettype wire

// ==== atc2_timer.sv ====
// Eight-bit timer with two compare channels behind an AXI4-Lite slave.
//
// Functional notes
// - Force strobe applies match to waveform output.
// - Forced match sets no flag, no clear.
// - Force strobe bits always read zero.
// - Reserved bits read as zero.
// - Clock select: stop, undivided, or prescaled.
// - Counter is readable and writable live.
// - Counter write blocks next compare match.
// - Compare registers continuously compared with counter.
// - Mask enables gate flags with global bit.
// - Flags set on events, clear by vector/one.
// - Phase PWM overflow flag at bottom turn.
// - External clock enable selects input buffer.
// - Async select chooses oscillator or I/O clock.
// - Async counter write sets busy until transfer.
// - Waveform mode sets sequence and top.
// - Async reads: live counter, control and compare from shadow.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module atc2_timer
  import atc2_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_osc_input,
  input wire logic global_irq_enable,
  input wire logic [2:0] vector_ack,
  output logic [2:0] irq_request,
  output logic osc_buffer_enable,
  output logic crystal_osc_enable,
  output logic waveform_out_a,
  output logic waveform_out_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [9:0] aw_idx_r, aw_idx_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_fire, wr_en, rd_fire;
  logic [9:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit, wr_hit;

  // Timer state declared early for the read mux.
  logic [7:0] ctrl_a_sh_r, ctrl_a_r, ocra_sh_r, ocra_r, ocrb_sh_r, ocrb_r, cnt_sh_r, count_r;
  logic [3:0] ctrl_b_sh_r, ctrl_b_r;
  logic [4:0] busy_r;
  logic external_clock_enable_r, async_r;
  logic [2:0] mask_r, flags_r;

  function automatic logic known_idx(input logic [9:0] idx);
    known_idx = idx == IDX_CONTROL_A || idx == IDX_CONTROL_B || idx == IDX_COUNTER ||
                idx == IDX_COMPARE_A || idx == IDX_COMPARE_B || idx == IDX_IRQ_MASK ||
                idx == IDX_ASYNC_STATUS || idx == IDX_IRQ_FLAGS;
  endfunction

  always_comb begin
    s_axi_awready = !aw_ok_r && !bvalid_r;
    s_axi_wready = !w_ok_r && !bvalid_r;
    s_axi_arready = !rvalid_r;
    wr_fire = aw_ok_r && w_ok_r && !bvalid_r;
    wr_hit = known_idx(aw_idx_r);
    wr_en = wr_fire && wstrb_r && wr_hit;
    rd_fire = s_axi_arvalid && s_axi_arready;
    rd_idx = s_axi_araddr[ADDR_W-1:2];
    rd_hit = known_idx(rd_idx);
    rd_byte = RESET_BYTE;
    unique case (rd_idx)
      IDX_CONTROL_A: rd_byte = ctrl_a_sh_r & CA_MASK;
      IDX_CONTROL_B: rd_byte = {4'h0, ctrl_b_sh_r};
      IDX_COUNTER: rd_byte = count_r;
      IDX_COMPARE_A: rd_byte = ocra_sh_r;
      IDX_COMPARE_B: rd_byte = ocrb_sh_r;
      IDX_IRQ_MASK: rd_byte = {5'h00, mask_r};
      IDX_ASYNC_STATUS: rd_byte = {1'b0, external_clock_enable_r, async_r, busy_r};
      IDX_IRQ_FLAGS: rd_byte = {5'h00, flags_r};
      default: rd_byte = RESET_BYTE;
    endcase
    aw_ok_nxt = aw_ok_r;
    aw_idx_nxt = aw_idx_r;
    w_ok_nxt = w_ok_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_nxt = 1'b1;
      wdata_nxt = s_axi_wdata[7:0];
      wstrb_nxt = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_byte};
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      aw_idx_r <= 10'h000;
      w_ok_r <= 1'b0;
      wdata_r <= RESET_BYTE;
      wstrb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      aw_ok_r <= aw_ok_nxt;
      aw_idx_r <= aw_idx_nxt;
      w_ok_r <= w_ok_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Counter, configuration and flags.

  logic [7:0] ctrl_a_sh_nxt, ctrl_a_nxt, ocra_sh_nxt, ocra_nxt, ocrb_sh_nxt, ocrb_nxt;
  logic [7:0] cnt_sh_nxt, count_nxt, top;
  logic [3:0] ctrl_b_sh_nxt, ctrl_b_nxt;
  logic [4:0] busy_nxt;
  logic external_clock_enable_nxt, async_nxt, down_r, down_nxt, block_r, block_nxt, osc_q_r;
  logic [2:0] mask_nxt, flags_nxt, flag_set, flag_clr;
  logic [2:0] wgm;
  atc2_wave_t wave;
  logic src_tick, tick, match_a, match_b, force_a, force_b, at_bottom;

  always_comb begin
    wgm = {ctrl_b_r[CB_WGM_HIGH], ctrl_a_r[1:0]};
    // Mode field picks counting sequence and top value.
    unique case (wgm)
      3'h1, 3'h5: wave = WAVE_PHASE;
      3'h2: wave = WAVE_CTC;
      3'h3, 3'h7: wave = WAVE_FAST;
      default: wave = WAVE_NORMAL;
    endcase
    top = (wgm[2] || wave == WAVE_CTC) ? ocra_r : COUNT_MAX;
    // I/O clock when zero, oscillator edges when one.
    src_tick = async_r ? (timer_osc_input && !osc_q_r) : 1'b1;
    // Strobes only act in non-PWM modes and store nothing.
    force_a = wr_en && aw_idx_r == IDX_CONTROL_B && wdata_r[CB_FORCE_A] &&
              (wave == WAVE_NORMAL || wave == WAVE_CTC);
    force_b = wr_en && aw_idx_r == IDX_CONTROL_B && wdata_r[CB_FORCE_B] &&
              (wave == WAVE_NORMAL || wave == WAVE_CTC);
    // A counter write removes the match at the next timer clock.
    match_a = tick && !block_r && count_r == ocra_r;
    match_b = tick && !block_r && count_r == ocrb_r;
    at_bottom = tick && wave == WAVE_FAST && count_r == top;
    ctrl_a_sh_nxt = ctrl_a_sh_r;
    ctrl_b_sh_nxt = ctrl_b_sh_r;
    ocra_sh_nxt = ocra_sh_r;
    ocrb_sh_nxt = ocrb_sh_r;
    cnt_sh_nxt = cnt_sh_r;
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    ocra_nxt = ocra_r;
    ocrb_nxt = ocrb_r;
    busy_nxt = busy_r;
    external_clock_enable_nxt = external_clock_enable_r;
    async_nxt = async_r;
    mask_nxt = mask_r;
    down_nxt = down_r;
    block_nxt = tick ? 1'b0 : block_r;
    count_nxt = count_r;
    flag_set = 3'h0;
    if (tick) begin
      // Forced matches never reach this path, so they set no flag and clear nothing.
      unique case (wave)
        WAVE_NORMAL: begin
          count_nxt = count_r + 8'h01;
          flag_set[IRQ_OVERFLOW] = count_r == COUNT_MAX;
        end
        WAVE_CTC: begin
          count_nxt = (count_r == top) ? COUNT_BOTTOM : count_r + 8'h01;
          flag_set[IRQ_OVERFLOW] = count_r == COUNT_MAX;
        end
        WAVE_FAST: begin
          count_nxt = (count_r == top) ? COUNT_BOTTOM : count_r + 8'h01;
          flag_set[IRQ_OVERFLOW] = count_r == top;
        end
        WAVE_PHASE: begin
          if (!down_r) begin
            down_nxt = count_r == top;
            count_nxt = (count_r == top) ? count_r - 8'h01 : count_r + 8'h01;
          end else begin
            down_nxt = count_r != COUNT_BOTTOM;
            count_nxt = (count_r == COUNT_BOTTOM) ? count_r + 8'h01 : count_r - 8'h01;
            flag_set[IRQ_OVERFLOW] = count_r == COUNT_BOTTOM;
          end
        end
      endcase
    end
    flag_set[IRQ_COMPARE_A] = match_a;
    flag_set[IRQ_COMPARE_B] = match_b;
    // Pending async updates move over on the next source edge.
    if (src_tick) begin
      if (busy_r[UB_COUNTER]) count_nxt = cnt_sh_r;
      if (busy_r[UB_COMPARE_A]) ocra_nxt = ocra_sh_r;
      if (busy_r[UB_COMPARE_B]) ocrb_nxt = ocrb_sh_r;
      if (busy_r[UB_CONTROL_A]) ctrl_a_nxt = ctrl_a_sh_r;
      if (busy_r[UB_CONTROL_B]) ctrl_b_nxt = ctrl_b_sh_r;
      busy_nxt = RESET_BUSY;
    end
    flag_clr = vector_ack;
    if (wr_en) begin
      unique case (aw_idx_r)
        IDX_CONTROL_A: begin
          ctrl_a_sh_nxt = wdata_r & CA_MASK;
          if (async_r) busy_nxt[UB_CONTROL_A] = 1'b1;
          else ctrl_a_nxt = wdata_r & CA_MASK;
        end
        IDX_CONTROL_B: begin
          ctrl_b_sh_nxt = wdata_r[3:0];
          if (async_r) busy_nxt[UB_CONTROL_B] = 1'b1;
          else ctrl_b_nxt = wdata_r[3:0];
        end
        IDX_COUNTER: begin
          cnt_sh_nxt = wdata_r;
          block_nxt = 1'b1;
          if (async_r) busy_nxt[UB_COUNTER] = 1'b1;
          else count_nxt = wdata_r;
        end
        IDX_COMPARE_A: begin
          ocra_sh_nxt = wdata_r;
          if (async_r) busy_nxt[UB_COMPARE_A] = 1'b1;
          else ocra_nxt = wdata_r;
        end
        IDX_COMPARE_B: begin
          ocrb_sh_nxt = wdata_r;
          if (async_r) busy_nxt[UB_COMPARE_B] = 1'b1;
          else ocrb_nxt = wdata_r;
        end
        IDX_IRQ_MASK: mask_nxt = wdata_r[2:0];
        IDX_ASYNC_STATUS: begin
          external_clock_enable_nxt = wdata_r[AS_EXTERNAL_CLOCK_ENABLE];
          async_nxt = wdata_r[AS_ASYNC];
        end
        IDX_IRQ_FLAGS: flag_clr = flag_clr | wdata_r[2:0];
        default: flag_clr = vector_ack;
      endcase
    end
    // An event in the clearing cycle keeps its flag.
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_sh_r <= RESET_BYTE;
      ctrl_a_r <= RESET_BYTE;
      ctrl_b_sh_r <= RESET_CB;
      ctrl_b_r <= RESET_CB;
      ocra_sh_r <= RESET_BYTE;
      ocra_r <= RESET_BYTE;
      ocrb_sh_r <= RESET_BYTE;
      ocrb_r <= RESET_BYTE;
      cnt_sh_r <= RESET_BYTE;
      count_r <= RESET_BYTE;
      busy_r <= RESET_BUSY;
      external_clock_enable_r <= 1'b0;
      async_r <= 1'b0;
      mask_r <= RESET_IRQ;
      flags_r <= RESET_IRQ;
      down_r <= 1'b0;
      block_r <= 1'b0;
      osc_q_r <= 1'b0;
    end else begin
      ctrl_a_sh_r <= ctrl_a_sh_nxt;
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_sh_r <= ctrl_b_sh_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      ocra_sh_r <= ocra_sh_nxt;
      ocra_r <= ocra_nxt;
      ocrb_sh_r <= ocrb_sh_nxt;
      ocrb_r <= ocrb_nxt;
      cnt_sh_r <= cnt_sh_nxt;
      count_r <= count_nxt;
      busy_r <= busy_nxt;
      external_clock_enable_r <= external_clock_enable_nxt;
      async_r <= async_nxt;
      mask_r <= mask_nxt;
      flags_r <= flags_nxt;
      down_r <= down_nxt;
      block_r <= block_nxt;
      osc_q_r <= timer_osc_input;
    end
  end

  assign irq_request = flags_r & mask_r & {3{global_irq_enable}};
  assign osc_buffer_enable = external_clock_enable_r && async_r;
  assign crystal_osc_enable = async_r && !external_clock_enable_r;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and compare channels.

  atc2_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_tick(src_tick),
    .clock_select_field(ctrl_b_r[2:0]),
    .tick(tick)
  );

  atc2_compare u_compare_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .match(match_a),
    .force_strobe(force_a),
    .at_bottom(at_bottom),
    .counting_down(down_r),
    .toggle_ok(ctrl_b_r[CB_WGM_HIGH]),
    .wave(wave),
    .output_mode(ctrl_a_r[CA_COM_A_LSB+1:CA_COM_A_LSB]),
    .wave_out(waveform_out_a)
  );

  atc2_compare u_compare_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .match(match_b),
    .force_strobe(force_b),
    .at_bottom(at_bottom),
    .counting_down(down_r),
    .toggle_ok(1'b0),
    .wave(wave),
    .output_mode(ctrl_a_r[CA_COM_B_LSB+1:CA_COM_B_LSB]),
    .wave_out(waveform_out_b)
  );

endmodule
`default_nettype wire

// ==== atc2_timer_monitor.sv ====
// Checker with bus and output assertions for the timer block.
`timescale 1ns/1ns
`default_nettype none
module atc2_timer_monitor
  import atc2_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic global_irq_enable,
  input wire logic [2:0] irq_request,
  input wire logic osc_buffer_enable,
  input wire logic crystal_osc_enable
);
  logic [9:0] rd_idx_r;
  logic [9:0] rd_idx_nxt;
  always_comb begin
    rd_idx_nxt = rd_idx_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rd_idx_nxt = s_axi_araddr[11:2];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx_r <= 10'h000;
    end else begin
      rd_idx_r <= rd_idx_nxt;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_answer; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_release; s_axi_bvalid && s_axi_bready |=> $fell(s_axi_bvalid); endproperty
  a_b_release: assert property (p_b_release) else $error("write answer kept");
  property p_wr_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("write taken early");
  property p_rd_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("read taken early");
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_ctrl_b_zero;
    s_axi_rvalid && rd_idx_r == IDX_CONTROL_B |-> s_axi_rdata[7:4] == 4'h0;
  endproperty
  a_ctrl_b_zero: assert property (p_ctrl_b_zero) else $error("strobe bits read");
  property p_status_top;
    s_axi_rvalid && rd_idx_r == IDX_ASYNC_STATUS |-> !s_axi_rdata[7];
  endproperty
  a_status_top: assert property (p_status_top) else $error("status bit 7 set");
  property p_irq_gate; !global_irq_enable |-> irq_request == 3'h0; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without global");
  property p_osc_excl; !(osc_buffer_enable && crystal_osc_enable); endproperty
  a_osc_excl: assert property (p_osc_excl) else $error("both osc paths on");
endmodule
bind atc2_timer atc2_timer_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .global_irq_enable, .irq_request,
  .osc_buffer_enable, .crystal_osc_enable);
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench of the timer block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import atc2_pkg::*;
  logic aclk, aresetn, awv, wv, bready, arv, rready, osc, gie;
  logic awrdy, wrdy, bv, arrdy, rv, obe, coe, wa, wb;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, lresp;
  logic [2:0] vack, irq;
  int fails = 0;
  int checked = 0;
  atc2_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .timer_osc_input(osc),
    .global_irq_enable(gie), .vector_ack(vack), .irq_request(irq), .osc_buffer_enable(obe),
    .crystal_osc_enable(coe), .waveform_out_a(wa), .waveform_out_b(wb));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [31:0] lo, hi, g);
    checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fails++;
      $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic got;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      got = bv;
      lresp = bresp;
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (got !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx);
    logic got;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      got = rv;
      rd_d = rdata;
      lresp = rresp;
      if (arv && arrdy) arv <= 1'b0;
    end while (got !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [31:0] e, input string nm);
    rd(idx);
    chk(nm, e, rd_d);
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [9:0] ix[7] = '{IDX_CONTROL_A, IDX_CONTROL_B, IDX_COUNTER, IDX_COMPARE_A,
      IDX_COMPARE_B, IDX_IRQ_MASK, IDX_ASYNC_STATUS};
    foreach (ix[i]) rdc(ix[i], 32'h0, "reset_value");
    rdc(IDX_IRQ_FLAGS, 32'h0, "reset_flags");
    wr(IDX_CONTROL_B, 8'hF8);
    rdc(IDX_CONTROL_B, 32'h8, "control_b");
    wr(IDX_CONTROL_B, 8'h00);
    wr(IDX_COUNTER, 8'hA5);
    rdc(IDX_COUNTER, 32'hA5, "counter");
    rdc(10'h000, 32'h0, "unmapped_rdata");
    chk("unmapped_rresp", 32'(RESP_SLVERR), 32'(lresp));
    wr(10'h000, 8'h55);
    chk("unmapped_bresp", 32'(RESP_SLVERR), 32'(lresp));
    $display("register test done");
  endtask
  task automatic t_clk;
    int dv[8] = '{10, 1, 8, 32, 64, 128, 256, 1024};
    for (int c = 0; c < 8; c++) begin
      wr(IDX_COUNTER, 8'h00);
      wr(IDX_CONTROL_B, 8'(c));
      run(4 * dv[c]);
      wr(IDX_CONTROL_B, 8'h00);
      rd(IDX_COUNTER);
      chk_rng("count", (c == 0) ? 0 : 3, (c == 0) ? 0 : ((c == 1) ? 9 : 5), rd_d);
    end
    $display("clock select test done");
  endtask
  task automatic t_match;
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_COMPARE_A, 8'h10);
    wr(IDX_COMPARE_B, 8'h20);
    wr(IDX_COUNTER, 8'h00);
    wr(IDX_IRQ_MASK, 8'h07);
    gie <= 1'b1;
    wr(IDX_CONTROL_B, 8'h01);
    run(60);
    wr(IDX_CONTROL_B, 8'h00);
    rdc(IDX_IRQ_FLAGS, 32'h6, "flags_match");
    chk("irq_on", 32'h6, 32'(irq));
    gie <= 1'b0;
    run(1);
    chk("irq_off", 32'h0, 32'(irq));
    wr(IDX_IRQ_FLAGS, 8'h02);
    rdc(IDX_IRQ_FLAGS, 32'h4, "flags_w1c");
    vack <= 3'h4;
    run(1);
    vack <= 3'h0;
    rdc(IDX_IRQ_FLAGS, 32'h0, "flags_vector");
    wr(IDX_COUNTER, 8'hF0);
    wr(IDX_CONTROL_B, 8'h01);
    run(30);
    wr(IDX_CONTROL_B, 8'h00);
    rd(IDX_IRQ_FLAGS);
    chk("overflow", 32'h1, 32'(rd_d[0]));
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_COMPARE_A, 8'h50);
    wr(IDX_COUNTER, 8'h50);
    wr(IDX_CONTROL_B, 8'h01);
    run(3);
    wr(IDX_CONTROL_B, 8'h00);
    rdc(IDX_IRQ_FLAGS, 32'h0, "blocked_match");
    $display("match test done");
  endtask
  task automatic t_force;
    wr(IDX_CONTROL_A, 8'h72);
    wr(IDX_COUNTER, 8'h33);
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_CONTROL_B, 8'hC0);
    chk("wave_a", 32'h1, 32'(wa));
    chk("wave_b", 32'h1, 32'(wb));
    rdc(IDX_COUNTER, 32'h33, "ctc_no_clear");
    rdc(IDX_IRQ_FLAGS, 32'h0, "force_no_flag");
    wr(IDX_CONTROL_B, 8'hC0);
    chk("wave_a_toggle", 32'h0, 32'(wa));
    chk("wave_b_set", 32'h1, 32'(wb));
    wr(IDX_CONTROL_A, 8'h00);
    $display("force test done");
  endtask
  task automatic t_phase;
    wr(IDX_COUNTER, 8'h03);
    wr(IDX_CONTROL_A, 8'h01);
    wr(IDX_IRQ_FLAGS, 8'h07);
    wr(IDX_CONTROL_B, 8'h01);
    run(300);
    rd(IDX_IRQ_FLAGS);
    chk("ovf_at_top", 32'h0, 32'(rd_d[0]));
    run(300);
    rd(IDX_IRQ_FLAGS);
    chk("ovf_at_bottom", 32'h1, 32'(rd_d[0]));
    wr(IDX_CONTROL_B, 8'h00);
    wr(IDX_CONTROL_A, 8'h00);
    $display("phase test done");
  endtask
  task automatic t_top;
    wr(IDX_COMPARE_A, 8'h05);
    for (int m = 0; m < 2; m++) begin
      wr(IDX_COUNTER, 8'h00);
      wr(IDX_CONTROL_A, m ? 8'h03 : 8'h02);
      wr(IDX_CONTROL_B, m ? 8'h09 : 8'h01);
      run(20);
      rd(IDX_COUNTER);
      wr(IDX_CONTROL_B, 8'h00);
      chk_rng("mode_top", 0, 5, rd_d);
    end
    wr(IDX_CONTROL_A, 8'h00);
    $display("top test done");
  endtask
  task automatic t_async;
    wr(IDX_COUNTER, 8'h11);
    wr(IDX_ASYNC_STATUS, 8'h40);
    chk("buf_idle", 32'h0, 32'({obe, coe}));
    wr(IDX_ASYNC_STATUS, 8'h60);
    chk("buf_ext", 32'h2, 32'({obe, coe}));
    wr(IDX_ASYNC_STATUS, 8'h20);
    chk("buf_xtal", 32'h1, 32'({obe, coe}));
    wr(IDX_CONTROL_A, 8'h00);
    wr(IDX_COMPARE_A, 8'h77);
    wr(IDX_COUNTER, 8'h5A);
    rdc(IDX_ASYNC_STATUS, 32'h3A, "busy_set");
    rdc(IDX_COUNTER, 32'h11, "async_live");
    rdc(IDX_COMPARE_A, 32'h77, "async_shadow");
    osc <= 1'b1;
    run(4);
    osc <= 1'b0;
    run(4);
    rdc(IDX_ASYNC_STATUS, 32'h20, "busy_clear");
    rdc(IDX_COUNTER, 32'h5A, "async_counter");
    wr(IDX_ASYNC_STATUS, 8'h00);
    $display("async test done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    run(40000);
    fails++;
    close_out;
  end
  initial begin
    aresetn = 1'b0;
    {awv, wv, bready, arv, rready, osc, gie} = 7'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    vack = 3'h0;
    run(3);
    aresetn <= 1'b1;
    t_regs;
    t_clk;
    t_match;
    t_force;
    t_phase;
    t_top;
    t_async;
    close_out;
  end
endmodule
`default_nettype wire
